// ===== include/pmcs_pkg.sv
// constants, encodings and types of the power-mode clock switcher
// assumes one 40 MHz bus clock; oscillators are observed as raw levels
package pmcs_pkg;

    // register byte addresses on the bus
    localparam logic [7:0] PMCS_OSC_CTRL_ADDR = 8'h00;
    localparam logic [7:0] PMCS_SEC_TMR_ADDR = 8'h04;
    localparam logic [7:0] PMCS_CFG_ADDR = 8'h08;
    localparam logic [7:0] PMCS_STAT_ADDR = 8'h0c;

    // oscillator_control_reg fields
    localparam int PMCS_IDLE_BIT = 7;
    localparam int PMCS_PRI_ACT_BIT = 3;
    localparam int PMCS_SCS_LSB = 0;

    // sec_timer_control fields
    localparam int PMCS_SEC_ACT_BIT = 6;
    localparam int PMCS_SEC_EN_BIT = 3;

    // configuration register fields
    localparam int PMCS_CFG_DFLT_BIT = 0;
    localparam int PMCS_CFG_TWO_SPEED_BIT = 1;
    localparam int PMCS_CFG_FAIL_SAFE_BIT = 2;
    localparam int PMCS_CFG_WDT_BIT = 3;
    localparam logic [3:0] PMCS_CFG_RST = 4'h1;

    // status register fields
    localparam int PMCS_STAT_MODE_LSB = 0;
    localparam int PMCS_STAT_SRC_LSB = 4;
    localparam int PMCS_STAT_BUSY_BIT = 6;
    localparam int PMCS_STAT_RDY_LSB = 8;

    // system clock select codes
    localparam logic [1:0] PMCS_SCS_DFLT = 2'h0;
    localparam logic [1:0] PMCS_SCS_SEC = 2'h1;
    localparam logic [1:0] PMCS_SCS_PRI = 2'h2;
    localparam logic [1:0] PMCS_SCS_INT = 2'h3;

    // reset values
    localparam logic [1:0] PMCS_SCS_RST = 2'h0;
    localparam logic PMCS_IDLE_RST = 1'b0;
    localparam logic PMCS_SEC_EN_RST = 1'b0;

    // switch pause: edges of the old and of the new source
    localparam logic [1:0] PMCS_OLD_TICKS = 2'h2;
    localparam logic [1:0] PMCS_NEW_TICKS = 2'h3;

    // clock sources, also the bit index into ready/tick vectors
    typedef enum logic [1:0] {
        PMCS_SRC_PRI = 2'h0,
        PMCS_SRC_SEC = 2'h1,
        PMCS_SRC_INT = 2'h2
    } pmcs_src_t;

    // power modes
    typedef enum logic [3:0] {
        PMCS_M_RUN = 4'h1,
        PMCS_M_IDLE = 4'h2,
        PMCS_M_SLEEP = 4'h4,
        PMCS_M_WAKE = 4'h8
    } pmcs_mode_t;

    // switch sequencer states
    typedef enum logic [3:0] {
        PMCS_SW_STEADY = 4'h1,
        PMCS_SW_WAIT = 4'h2,
        PMCS_SW_OLD = 4'h4,
        PMCS_SW_NEW = 4'h8
    } pmcs_sw_t;

    // select field to source; code 00 follows the default-source bit
    function automatic pmcs_src_t pmcs_decode_src(input logic [1:0] sys_clk_select,
                                                  input logic dflt);
        pmcs_src_t src;
        src = PMCS_SRC_PRI;
        if (sys_clk_select == PMCS_SCS_SEC)
            src = PMCS_SRC_SEC;
        else if (sys_clk_select == PMCS_SCS_INT)
            src = PMCS_SRC_INT;
        else if (sys_clk_select == PMCS_SCS_DFLT && !dflt)
            src = PMCS_SRC_INT;
        return src;
    endfunction

endpackage

// ===== verilog/pmcs_switcher.sv
// glitch-free source switch sequencer
// assumes tick inputs are one-cycle pulses per source clock edge
`timescale 1ns/10ps
module pmcs_switcher
    import pmcs_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire pmcs_src_t target,
    input wire logic allow,
    input wire logic load_en,
    input wire pmcs_src_t load_src,
    input wire logic [2:0] src_ready,
    input wire logic [2:0] src_tick,
    output pmcs_src_t active_src,
    output logic clk_pause,
    output logic busy
);

    pmcs_sw_t state_q; // sequencer state
    pmcs_src_t act_q; // source driving the system
    pmcs_src_t new_q; // source being switched to
    logic [1:0] cnt_q; // edge counter

    // edge of the old or of the new source, per state
    wire logic old_tick = src_tick[act_q];
    wire logic new_tick = src_tick[new_q];
    wire logic new_ready = src_ready[new_q];

    // sequencer; select only moves while the clocks are paused
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= PMCS_SW_STEADY;
            act_q <= PMCS_SRC_PRI;
            new_q <= PMCS_SRC_PRI;
            cnt_q <= 2'h0;
        end
        else if (load_en)
        begin
            // direct load, only while clocks are withheld
            act_q <= load_src;
            state_q <= PMCS_SW_STEADY;
        end
        else
        begin
            unique case (state_q)
                PMCS_SW_STEADY:
                begin
                    // new request: remember it, wait for it to run
                    if (allow && target != act_q)
                    begin
                        new_q <= target;
                        cnt_q <= 2'h0;
                        state_q <= PMCS_SW_WAIT;
                    end
                end
                PMCS_SW_WAIT:
                begin
                    // old source keeps clocking while a new primary or internal one starts
                    if (!allow || target != new_q)
                        state_q <= PMCS_SW_STEADY;
                    else if (new_ready)
                        state_q <= PMCS_SW_OLD;
                end
                PMCS_SW_OLD:
                begin
                    // two old edges, then the clocks pause
                    if (old_tick)
                    begin
                        cnt_q <= cnt_q + 2'h1;
                        if (cnt_q == PMCS_OLD_TICKS - 2'h1)
                        begin
                            cnt_q <= 2'h0;
                            state_q <= PMCS_SW_NEW;
                        end
                    end
                end
                PMCS_SW_NEW:
                begin
                    // three new edges in the pause, then hand over
                    if (new_tick)
                    begin
                        cnt_q <= cnt_q + 2'h1;
                        if (cnt_q == PMCS_NEW_TICKS - 2'h1)
                        begin
                            act_q <= new_q;
                            state_q <= PMCS_SW_STEADY;
                        end
                    end
                end
            endcase
        end
    end

    // pause in the last phase; a secondary source that has not started
    // holds the clocks off already while waiting
    assign clk_pause = (state_q == PMCS_SW_NEW) ||
        (state_q == PMCS_SW_WAIT && new_q == PMCS_SRC_SEC);
    assign busy = (state_q != PMCS_SW_STEADY);
    assign active_src = act_q;

endmodule // pmcs_switcher

// ===== verilog/pmcs_power_clock.sv
// power-mode sequencer, clock gating and status of the clock switcher
// assumes an apb master on pclk, raw oscillator levels and ready pins
// from outside, and sleep/wake pulses from core logic on pclk
//
// Summary of operation
// - select codes 10 pri, 01 sec, 11 internal
// - sleep: idle bit 0 sleeps, 1 idles
// - switch pauses two old, three new edges
// - flags show primary or secondary driving clocks
// - each sleep samples idle bit then
// - run modes clock cpu and peripherals
// - reset starts in primary run, flag set
// - select 01 moves to secondary, primary off
// - secondary disabled blocks secondary run
// - secondary not started holds clocks off
// - secondary to primary waits primary ready
// - select 11 moves to internal, primary off
// - internal to primary waits; bits untouched
// - internal keeps running for watchdog, monitor
// - sleep stops source, clears status flags
// - sleep keeps watchdog, secondary oscillators
// - wake waits for source or internal
// - reset clears select field
// - select 00 follows default-source bit
// - switching is glitch-free with short pause
`timescale 1ns/10ps
module pmcs_power_clock
    import pmcs_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sleep_exec,
    input wire logic wake_irq,
    input wire logic wake_reset,
    input wire logic wake_wdt,
    input wire logic [2:0] osc_clk_in,
    input wire logic [2:0] osc_ready_in,
    output logic cpu_clk_en,
    output logic periph_clk_en,
    output logic [1:0] clk_src_sel,
    output logic pri_osc_run,
    output logic sec_osc_run,
    output logic int_osc_run,
    output logic [3:0] power_mode
);

    // software-visible control bits
    logic idle_on_sleep_q; // idle instead of sleep
    logic [1:0] sys_clk_select_q; // source select field
    logic sec_osc_enable_q; // secondary oscillator enable
    logic [3:0] cfg_q; // default source, two-speed, monitor, watchdog

    // status flags
    logic primary_clk_active_q; // primary drives system
    logic sec_clk_active_q; // secondary drives system

    // mode sequencer
    pmcs_mode_t mode_q; // current power mode
    pmcs_mode_t mode_d; // next power mode

    // pin synchronisers: oscillator levels in [2:0], ready in [5:3]
    logic [5:0] syn1_q; // first stage, read only by second
    logic [5:0] syn2_q; // second stage
    logic [5:0] syn3_q; // third stage
    logic [5:0] flt_q; // accepted level

    // registered outputs
    logic [31:0] prdata_q; // read data, loaded in setup phase
    logic cpu_clk_en_q; // cpu clock gate
    logic periph_clk_en_q; // peripheral clock gate
    logic pri_osc_run_q; // primary oscillator enable
    logic sec_osc_run_q; // secondary oscillator enable
    logic int_osc_run_q; // internal oscillator enable

    // switcher outputs
    pmcs_src_t act_src; // source now driving
    logic sw_pause; // clocks paused for a switch
    logic sw_busy; // a switch is under way

    // accept a new level only once stages two and three agree
    wire logic [5:0] flt_d = (syn2_q & syn3_q) |
        (flt_q & (syn2_q | syn3_q));
    // rising edge of each oscillator as a one-cycle tick
    wire logic [2:0] src_tick = ~flt_q[2:0] & syn2_q[2:0] & syn3_q[2:0];
    wire logic [2:0] src_ready = flt_q[5:3];

    // configuration bits
    wire logic dflt_src = cfg_q[PMCS_CFG_DFLT_BIT];
    wire logic two_speed = cfg_q[PMCS_CFG_TWO_SPEED_BIT];
    wire logic fail_safe = cfg_q[PMCS_CFG_FAIL_SAFE_BIT];
    wire logic wdt_en = cfg_q[PMCS_CFG_WDT_BIT];

    // requested source from the select field
    wire pmcs_src_t target = pmcs_decode_src(sys_clk_select_q,
        dflt_src);
    // a disabled secondary oscillator may not be selected
    wire logic target_ok = !(target == PMCS_SRC_SEC &&
        !sec_osc_enable_q);
    // source to aim for; a refused request keeps the current one
    wire pmcs_src_t tgt_eff = target_ok ? target : act_src;

    // mode decoding
    wire logic in_run = (mode_q == PMCS_M_RUN);
    wire logic in_idle = (mode_q == PMCS_M_IDLE);
    wire logic in_wake = (mode_q == PMCS_M_WAKE);
    wire logic awake = in_run || in_idle;
    // merged wake request
    wire logic wake_req = wake_irq || wake_reset || wake_wdt;

    // wake from sleep: the selected source is ready, or the internal
    // oscillator may stand in for it
    wire logic wake_rdy = src_ready[tgt_eff];
    wire logic wake_alt = two_speed || fail_safe;
    wire logic wake_load = in_wake && (wake_rdy || wake_alt);
    wire pmcs_src_t wake_src = wake_rdy ? tgt_eff : PMCS_SRC_INT;

    // apb decode
    wire logic apb_setup = psel && !penable;
    wire logic apb_acc = psel && penable;
    wire logic hit_ctrl = (paddr == PMCS_OSC_CTRL_ADDR);
    wire logic hit_sec = (paddr == PMCS_SEC_TMR_ADDR);
    wire logic hit_cfg = (paddr == PMCS_CFG_ADDR);
    wire logic hit_stat = (paddr == PMCS_STAT_ADDR);
    wire logic hit_any = hit_ctrl || hit_sec || hit_cfg || hit_stat;
    wire logic wr_en = apb_acc && pwrite;

    // read words; unused bits read as zero
    wire logic [31:0] rd_ctrl =
        (32'(idle_on_sleep_q) << PMCS_IDLE_BIT) |
        (32'(primary_clk_active_q) << PMCS_PRI_ACT_BIT) |
        (32'(sys_clk_select_q) << PMCS_SCS_LSB);
    wire logic [31:0] rd_sec =
        (32'(sec_clk_active_q) << PMCS_SEC_ACT_BIT) |
        (32'(sec_osc_enable_q) << PMCS_SEC_EN_BIT);
    wire logic [31:0] rd_stat =
        (32'(mode_q) << PMCS_STAT_MODE_LSB) |
        (32'(act_src) << PMCS_STAT_SRC_LSB) |
        (32'(sw_busy) << PMCS_STAT_BUSY_BIT) |
        (32'(src_ready) << PMCS_STAT_RDY_LSB);
    wire logic [31:0] rd_word = hit_ctrl ? rd_ctrl :
        hit_sec ? rd_sec :
        hit_cfg ? 32'(cfg_q) :
        hit_stat ? rd_stat : 32'h0;

    // pin synchronisers and level filter
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            syn1_q <= 6'h00;
            syn2_q <= 6'h00;
            syn3_q <= 6'h00;
            flt_q <= 6'h00;
        end
        else
        begin
            syn1_q <= {osc_ready_in, osc_clk_in};
            syn2_q <= syn1_q;
            syn3_q <= syn2_q;
            flt_q <= flt_d;
        end
    end

    // software registers; hardware never rewrites select or idle bits
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            idle_on_sleep_q <= PMCS_IDLE_RST;
            sys_clk_select_q <= PMCS_SCS_RST;
            sec_osc_enable_q <= PMCS_SEC_EN_RST;
            cfg_q <= PMCS_CFG_RST;
        end
        else if (wr_en)
        begin
            // writes to the select field act at once
            if (hit_ctrl)
            begin
                idle_on_sleep_q <= pwdata[PMCS_IDLE_BIT];
                sys_clk_select_q <= pwdata[PMCS_SCS_LSB +: 2];
            end
            if (hit_sec)
                sec_osc_enable_q <= pwdata[PMCS_SEC_EN_BIT];
            if (hit_cfg)
                cfg_q <= pwdata[3:0];
        end
    end

    // read data is captured in the setup phase, ready in access
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_q <= 32'h0;
        else if (apb_setup && !pwrite)
            prdata_q <= rd_word;
    end

    // mode sequencer next state
    always_comb
    begin
        mode_d = mode_q;
        unique case (mode_q)
            PMCS_M_RUN:
            begin
                // idle bit sampled as the instruction executes;
                // a sleep pulse that comes while a switch is in progress is ignored
                if (sleep_exec && !sw_busy)
                    mode_d = idle_on_sleep_q ? PMCS_M_IDLE
                                             : PMCS_M_SLEEP;
            end
            PMCS_M_IDLE:
            begin
                // back to the run mode of the current select
                if (wake_req)
                    mode_d = PMCS_M_RUN;
            end
            PMCS_M_SLEEP:
            begin
                // no clock switch on entry, only a wake ends it
                if (wake_req)
                    mode_d = PMCS_M_WAKE;
            end
            PMCS_M_WAKE:
            begin
                // clocks withheld until a source can be used
                if (wake_load)
                    mode_d = PMCS_M_RUN;
            end
        endcase
    end

    // mode register; reset lands in primary run
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mode_q <= PMCS_M_RUN;
        else
            mode_q <= mode_d;
    end

    // status flags follow the source that really drives the system;
    // both clear while asleep or waking
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            primary_clk_active_q <= 1'b1;
            sec_clk_active_q <= 1'b0;
        end
        else
        begin
            primary_clk_active_q <= awake &&
                act_src == PMCS_SRC_PRI;
            sec_clk_active_q <= awake &&
                act_src == PMCS_SRC_SEC;
        end
    end

    // clock gates and oscillator enables
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cpu_clk_en_q <= 1'b1;
            periph_clk_en_q <= 1'b1;
            pri_osc_run_q <= 1'b1;
            sec_osc_run_q <= 1'b0;
            int_osc_run_q <= 1'b0;
        end
        else
        begin
            // run clocks both, idle only peripherals, pause gates all
            cpu_clk_en_q <= in_run && !sw_pause;
            periph_clk_en_q <= awake && !sw_pause;
            // primary runs while it drives or is being started for a
            // switch; it stops when switched away and in sleep
            pri_osc_run_q <= (awake && (act_src == PMCS_SRC_PRI ||
                tgt_eff == PMCS_SRC_PRI)) ||
                (in_wake && tgt_eff == PMCS_SRC_PRI);
            // secondary follows its enable in every mode
            sec_osc_run_q <= sec_osc_enable_q;
            // internal kept for watchdog or monitor, else on demand
            int_osc_run_q <= wdt_en || fail_safe ||
                (awake && (act_src == PMCS_SRC_INT ||
                tgt_eff == PMCS_SRC_INT)) ||
                (in_wake && (tgt_eff == PMCS_SRC_INT ||
                wake_alt));
        end
    end

    // switch sequencer; a refused secondary request never starts.
    // on wake the source is loaded directly, clocks being off then
    pmcs_switcher u_switcher (
        .clk (pclk),
        .rst_n (presetn),
        .target (target),
        .allow (awake && target_ok),
        .load_en (wake_load),
        .load_src (wake_src),
        .src_ready (src_ready),
        .src_tick (src_tick),
        .active_src (act_src),
        .clk_pause (sw_pause),
        .busy (sw_busy)
    );

    // output assignments
    assign prdata = prdata_q;
    assign pready = 1'b1;
    assign pslverr = apb_acc && !hit_any;
    assign cpu_clk_en = cpu_clk_en_q;
    assign periph_clk_en = periph_clk_en_q;
    assign clk_src_sel = act_src;
    assign pri_osc_run = pri_osc_run_q;
    assign sec_osc_run = sec_osc_run_q;
    assign int_osc_run = int_osc_run_q;
    assign power_mode = mode_q;

endmodule // pmcs_power_clock

// ===== sim/pmcs_power_clock_checker.sv
// port-level assertions for the power-mode clock switcher
// assumes a bind onto pmcs_power_clock, one pclk domain
`timescale 1ns/10ps
module pmcs_power_clock_checker (
    input logic pclk,
    input logic presetn,
    input logic psel,
    input logic penable,
    input logic [7:0] paddr,
    input logic pready,
    input logic pslverr,
    input logic sleep_exec,
    input logic wake_irq,
    input logic wake_reset,
    input logic wake_wdt,
    input logic cpu_clk_en,
    input logic periph_clk_en,
    input logic [1:0] clk_src_sel,
    input logic pri_osc_run,
    input logic [3:0] power_mode
);
    // all wake sources as one
    wire logic wake_any = wake_irq | wake_reset | wake_wdt;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // run mode, then sleep one edge later
    sequence s_to_sleep;
        power_mode == 4'h1 ##1 power_mode == 4'h4;
    endsequence
    // settled in sleep
    sequence s_asleep;
        power_mode == 4'h4 [*2];
    endsequence

    a_reset_primary_run:
        assert property ($rose(presetn) |-> power_mode == 4'h1 &&
            clk_src_sel == 2'h0 && cpu_clk_en)
        else $error("reset not primary run");
    a_sleep_cause:
        assert property (s_to_sleep |-> $past(sleep_exec))
        else $error("sleep without pulse");
    a_sleep_dark:
        assert property (s_asleep |-> !cpu_clk_en && !periph_clk_en &&
            !pri_osc_run)
        else $error("clocks on in sleep");
    a_idle_cpu_off:
        assert property (power_mode == 4'h2 [*2] |-> !cpu_clk_en &&
            periph_clk_en)
        else $error("idle clock enables wrong");
    a_sleep_wake:
        assert property (power_mode == 4'h4 && wake_any |=>
            power_mode == 4'h8)
        else $error("sleep ignored wake");
    a_idle_wake:
        assert property (power_mode == 4'h2 && wake_any |=>
            power_mode == 4'h1)
        else $error("idle ignored wake");
    a_wake_bound:
        assert property ($rose(power_mode == 4'h8) |-> ##[1:200]
            power_mode == 4'h1)
        else $error("wake wait too long");
    a_wait_dark:
        assert property (power_mode == 4'h8 |-> !cpu_clk_en)
        else $error("cpu clocked before source ready");
    a_switch_gap:
        assert property ($changed(clk_src_sel) |-> !cpu_clk_en &&
            !periph_clk_en)
        else $error("switch with clocks on");
    a_switch_back:
        assert property ($changed(clk_src_sel) && power_mode == 4'h1 |=>
            cpu_clk_en && periph_clk_en)
        else $error("clocks not back after switch");
    a_pri_off:
        assert property ($changed(clk_src_sel) && clk_src_sel != 2'h0 |->
            ##[0:2] !pri_osc_run)
        else $error("primary left running");
    a_bus_err_map:
        assert property (psel && penable |-> pslverr ==
            !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c}) && pready)
        else $error("bus response wrong");
endmodule // pmcs_power_clock_checker

bind pmcs_power_clock pmcs_power_clock_checker u_chk (
    .pclk, .presetn, .psel, .penable, .paddr, .pready, .pslverr,
    .sleep_exec, .wake_irq, .wake_reset, .wake_wdt, .cpu_clk_en,
    .periph_clk_en, .clk_src_sel, .pri_osc_run, .power_mode);

// ===== sim/pmcs_osc_model.sv
// behavioural bank of three oscillators facing the switcher
// assumes run enables from the design; [0] pri, [1] sec, [2] internal
`timescale 1ns/10ps
module pmcs_osc_model #(
    parameter int START = 8
) (
    input logic pclk,
    input logic [2:0] run,
    output logic [2:0] osc_clk = 3'h0,
    output logic [2:0] osc_ready = 3'h0
);
    int age [3]; // cycles since enable
    int ph [3]; // cycles into half period

    // each source: start-up delay, then a slow clock of half period i+2
    always @(posedge pclk)
    begin
        for (int i = 0; i < 3; i++)
        begin
            if (!run[i])
            begin
                // stopped: clock stands still low, not ready
                age[i] <= 0;
                ph[i] <= 0;
                osc_ready[i] <= 1'b0;
                osc_clk[i] <= 1'b0;
            end
            else if (age[i] < START)
                age[i] <= age[i] + 1;
            else
            begin
                osc_ready[i] <= 1'b1;
                // distinct rates so the switch counts differ
                ph[i] <= (ph[i] == i + 1) ? 0 : ph[i] + 1;
                if (ph[i] == i + 1)
                    osc_clk[i] <= ~osc_clk[i];
            end
        end
    end
endmodule // pmcs_osc_model

// ===== sim/test_power_mode_clock_switcher.sv
// self-checking bench of the power-mode clock switcher
// assumes the apb slave answers with pready; oscillators from a model
`timescale 1ns/10ps
module test_power_mode_clock_switcher;
    typedef struct {
        logic wr;
        logic [7:0] a;
        logic [31:0] d;
        logic [31:0] e;
    } pmcs_row_t;

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, sleep_exec;
    logic wake_irq, wake_reset, wake_wdt;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, cpu_clk_en, periph_clk_en;
    logic pri_osc_run, sec_osc_run, int_osc_run;
    logic [1:0] clk_src_sel;
    logic [3:0] power_mode;
    logic [2:0] osc_clk, osc_rdy;
    int fails = 0;
    int cmp_count = 0;
    int gap; // gated cycles of the last switch

    // plain register cases: write, or read and compare
    pmcs_row_t rows [9] = '{
        '{1'b0, 8'h00, 32'h0, 32'h08}, '{1'b0, 8'h04, 32'h0, 32'h00},
        '{1'b0, 8'h08, 32'h0, 32'h01}, '{1'b0, 8'h10, 32'h0, 32'h00},
        '{1'b1, 8'h00, 32'h80, 32'h0}, '{1'b0, 8'h00, 32'h0, 32'h88},
        '{1'b1, 8'h00, 32'h00, 32'h0}, '{1'b1, 8'h08, 32'h09, 32'h0},
        '{1'b0, 8'h08, 32'h0, 32'h09}};

    always #12.5 pclk = ~pclk;

    pmcs_power_clock u_pmcs_power_clock (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .sleep_exec, .wake_irq,
        .wake_reset, .wake_wdt, .osc_clk_in(osc_clk),
        .osc_ready_in(osc_rdy), .cpu_clk_en, .periph_clk_en,
        .clk_src_sel, .pri_osc_run, .sec_osc_run, .int_osc_run,
        .power_mode);

    pmcs_osc_model u_pmcs_osc_model (
        .pclk, .run({int_osc_run, sec_osc_run, pri_osc_run}),
        .osc_clk, .osc_ready(osc_rdy));

    // compare and count
    task automatic chk(input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("[ERR] %0t got %h want %h", $time, seen, exp);
        end
    endtask

    // one apb transfer; waits for pready, only the watchdog ends a hang
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // wait for a source; count gated cpu cycles
    task automatic wait_sel(input logic [1:0] v);
        gap = 0;
        while (clk_src_sel !== v)
        begin
            @(posedge pclk);
            if (cpu_clk_en !== 1'b1)
                gap++;
        end
        repeat (2) @(posedge pclk);
        chk(clk_src_sel, v);
    endtask

    // write c, sleep, wake by sources wk
    task automatic nap(input logic [31:0] c, input logic [2:0] wk,
                       input logic [3:0] m);
        apb(1'b1, 8'h00, c);
        sleep_exec <= 1'b1;
        @(posedge pclk);
        sleep_exec <= 1'b0;
        repeat (2) @(posedge pclk);
        chk(power_mode, m);
        chk(cpu_clk_en, 1'b0);
        chk(periph_clk_en, m == 4'h2);
        if (m == 4'h4)
        begin
            // sleep keeps the enabled secondary, flags cleared
            chk(sec_osc_run, 1'b1);
            apb(1'b0, 8'h04, 32'h0);
            chk(rd, 32'h08);
        end
        {wake_wdt, wake_reset, wake_irq} <= wk;
        @(posedge pclk);
        {wake_wdt, wake_reset, wake_irq} <= 3'h0;
        while (power_mode !== 4'h1) @(posedge pclk);
        repeat (2) @(posedge pclk);
        chk(cpu_clk_en, 1'b1);
        apb(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h48);
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, c);
    endtask

    // verdict, from main flow or watchdog
    task automatic conclude;
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // watchdog, well beyond the run
    initial
    begin
        #400000;
        fails++;
        conclude();
    end

    initial
    begin
        {psel, penable, pwrite, sleep_exec} = 4'h0;
        {wake_irq, wake_reset, wake_wdt} = 3'h0; // no wake source asserted at start
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(power_mode, 4'h1);
        foreach (rows[i])
        begin
            apb(rows[i].wr, rows[i].a, rows[i].d);
            if (!rows[i].wr)
                chk(rd, rows[i].e);
        end
        // primary to internal, pause length, back to primary
        apb(1'b1, 8'h00, 32'h03);
        wait_sel(2'h2);
        chk(gap >= 16 && gap <= 36, 1'b1);
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h03);
        apb(1'b1, 8'h00, 32'h02);
        wait_sel(2'h0);
        chk(int_osc_run, 1'b1);
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h0a);
        // secondary selected while disabled: no move
        apb(1'b1, 8'h00, 32'h01);
        repeat (60) @(posedge pclk);
        chk(clk_src_sel, 2'h0);
        // enable late so clocks are held off during start-up
        apb(1'b1, 8'h04, 32'h08);
        wait_sel(2'h1);
        chk(gap >= 8, 1'b1);
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h01);
        // idle, sleep, idle with each wake source
        nap(32'h81, 3'b001, 4'h2);
        nap(32'h01, 3'b100, 4'h4);
        nap(32'h81, 3'b010, 4'h2);
        // secondary back to primary, secondary kept running
        apb(1'b1, 8'h00, 32'h02);
        wait_sel(2'h0);
        chk(sec_osc_run, 1'b1);
        apb(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h08);
        // select 00 with default-source bit low goes internal
        apb(1'b1, 8'h08, 32'h08);
        apb(1'b1, 8'h00, 32'h00);
        wait_sel(2'h2);
        // reset in mid-run clears select and restarts primary
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h08);
        chk(clk_src_sel, 2'h0);
        conclude();
    end
endmodule // test_power_mode_clock_switcher
